// ### rtl/clock_manager.v
// Dual synthesiser clock manager with mode-dependent field ownership
`include "clkmgr_consts.vh"
module clock_manager (
  input wire CLK,
  input wire RST,
  input wire WR_EN,
  input wire RD_EN,
  input wire [6:0] ADDR,
  input wire [8:0] WDATA,
  output reg [8:0] RDATA,
  output reg RD_VALID,
  input wire RX_ENABLE,
  input wire RX_LOCKED,
  input wire RX_STREAM_PRESENT,
  input wire [3:0] RX_INTEGER,
  input wire [21:0] RX_FRACTION,
  input wire [1:0] RX_OUTDIV_MODE,
  input wire OSC_SELECT_MASTER,
  input wire OSC_SELECT_CLOCK_OUTPUT_PIN,
  output reg CRYSTAL_DRIVE_ON,
  output reg TRACKING_MODE,
  output reg [25:0] FIRST_SYNTH_RATIO,
  output reg [25:0] SECOND_SYNTH_RATIO,
  output reg FIRST_SYNTH_PREDIVIDE,
  output reg SECOND_SYNTH_PREDIVIDE,
  output reg [1:0] FIRST_SYNTH_OUTDIV_MODE,
  output reg FIRST_SYNTH_OUT,
  output reg SECOND_SYNTH_OUT,
  output reg FIRST_SYNTH_AVAILABLE,
  output reg SECOND_SYNTH_AVAILABLE,
  output reg [8:0] TRACK_FS_RATIO,
  output reg MASTER_CLOCK_FROM_OSC,
  output reg CLOCK_OUTPUT_FROM_OSC
);
  // ****************************************
  // Software registers
  // ****************************************
  reg [8:0] a_frac_low_ff;
  reg [8:0] a_frac_mid_ff;
  reg [8:0] a_frac_high_int_ff;
  reg [8:0] a_dividers_ff;
  reg [8:0] b_frac_low_ff;
  reg [8:0] b_frac_mid_ff;
  reg [8:0] b_frac_high_int_ff;
  reg [8:0] b_dividers_ff;
  reg [8:0] power_down_ff;

  // Register writes, one 9-bit word per address; 33h keeps only WDATA[2:0], upper bits zero
  always @(posedge CLK) begin
    if (RST) begin
      a_frac_low_ff <= `RST_FRAC_LOW;
      a_frac_mid_ff <= `RST_FRAC_MID;
      a_frac_high_int_ff <= `RST_FRAC_HIGH_INT;
      a_dividers_ff <= `RST_DIVIDERS;
      b_frac_low_ff <= `RST_FRAC_LOW;
      b_frac_mid_ff <= `RST_FRAC_MID;
      b_frac_high_int_ff <= `RST_FRAC_HIGH_INT;
      b_dividers_ff <= `RST_DIVIDERS;
      power_down_ff <= `RST_POWER_DOWN;
    end else if (WR_EN) begin
      case (ADDR)
        `OFS_A_FRAC_LOW: a_frac_low_ff <= WDATA;
        `OFS_A_FRAC_MID: a_frac_mid_ff <= WDATA;
        `OFS_A_FRAC_HIGH_INT: a_frac_high_int_ff <= WDATA;
        `OFS_A_DIVIDERS: a_dividers_ff <= WDATA;
        `OFS_B_FRAC_LOW: b_frac_low_ff <= WDATA;
        `OFS_B_FRAC_MID: b_frac_mid_ff <= WDATA;
        `OFS_B_FRAC_HIGH_INT: b_frac_high_int_ff <= WDATA;
        `OFS_B_DIVIDERS: b_dividers_ff <= WDATA;
        `OFS_POWER_DOWN: power_down_ff <= {6'h00, WDATA[2:0]};
        default: power_down_ff <= power_down_ff;
      endcase
    end
  end

  // ****************************************
  // Field decode helpers
  // ****************************************
  // Reassemble a 22-bit fraction from its three register pieces
  function [21:0] join_fraction;
    input [8:0] low;
    input [8:0] mid;
    input [8:0] high;
    begin
      join_fraction = {high[`POS_FRAC_HIGH_MSB:`POS_FRAC_HIGH_LSB], mid, low};
    end
  endfunction

  // Half period of the output divider in model clock cycles
  function [4:0] half_divide;
    input [1:0] mode;
    input post;
    reg [4:0] base;
    begin
      case (mode)
        2'h0: base = 5'h01;
        2'h1: base = 5'h02;
        2'h2: base = 5'h04;
        default: base = 5'h06;
      endcase
      half_divide = post ? {base[3:0], 1'b0} : base;
    end
  endfunction

  // ****************************************
  // Pin input synchronisers
  // ****************************************
  // Receiver status arrives from another clock domain
  reg [2:0] sync_enable_ff;
  reg [2:0] sync_locked_ff;
  reg [2:0] sync_present_ff;
  reg rx_enable_ff;
  reg rx_locked_ff;
  reg rx_present_ff;

  always @(posedge CLK) begin
    if (RST) begin
      sync_enable_ff <= 3'h0;
      sync_locked_ff <= 3'h0;
      sync_present_ff <= 3'h0;
    end else begin
      sync_enable_ff <= {sync_enable_ff[1:0], RX_ENABLE};
      sync_locked_ff <= {sync_locked_ff[1:0], RX_LOCKED};
      sync_present_ff <= {sync_present_ff[1:0], RX_STREAM_PRESENT};
    end
  end

  // Accept a change only once stages two and three agree
  always @(posedge CLK) begin
    if (RST) begin
      rx_enable_ff <= 1'b0;
      rx_locked_ff <= 1'b0;
      rx_present_ff <= 1'b0;
    end else begin
      if (sync_enable_ff[1] == sync_enable_ff[2]) rx_enable_ff <= sync_enable_ff[2];
      if (sync_locked_ff[1] == sync_locked_ff[2]) rx_locked_ff <= sync_locked_ff[2];
      if (sync_present_ff[1] == sync_present_ff[2]) rx_present_ff <= sync_present_ff[2];
    end
  end

  // ****************************************
  // Mode ownership of the first synthesiser
  // ****************************************
  reg [3:0] frozen_int_ff;
  reg [21:0] frozen_frac_ff;
  reg [3:0] a_int;
  reg [21:0] a_frac;
  reg [1:0] a_mode;
  wire tracking;
  wire a_run;

  assign tracking = rx_enable_ff;

  // Capture receiver values while a stream is present; hold when it stops
  always @(posedge CLK) begin
    if (RST) begin
      frozen_int_ff <= 4'h0;
      frozen_frac_ff <= 22'h000000;
    end else if (tracking & rx_present_ff) begin
      frozen_int_ff <= RX_INTEGER;
      frozen_frac_ff <= RX_FRACTION;
    end
  end

  // Receiver inputs are quasi-static settings from the tracking loop
  always @* begin
    if (tracking) begin
      a_int = rx_present_ff ? RX_INTEGER : frozen_int_ff;
      a_frac = rx_present_ff ? RX_FRACTION : frozen_frac_ff;
      a_mode = RX_OUTDIV_MODE;
    end else begin
      a_int = a_frac_high_int_ff[`POS_INT_MSB:`POS_INT_LSB];
      a_frac = join_fraction(a_frac_low_ff, a_frac_mid_ff, a_frac_high_int_ff);
      a_mode = a_dividers_ff[`POS_OUTDIV_MSB:`POS_OUTDIV_LSB];
    end
  end

  // Unlocked while tracking a new rate stops the output; loss of stream does not
  assign a_run = ~tracking | rx_locked_ff | ~rx_present_ff;

  // ****************************************
  // Synthesiser channels
  // ****************************************
  wire [25:0] a_ratio;
  wire [25:0] b_ratio;
  wire a_clk;
  wire b_clk;

  synth_divider u_first (
    .clk(CLK),
    .rst(RST),
    .power_off(power_down_ff[`POS_FIRST_OFF]),
    .run(a_run),
    .integer_part(a_int),
    .fraction(a_frac),
    .predivide(a_dividers_ff[`POS_PREDIV]),
    .divide_half(half_divide(a_mode, a_dividers_ff[`POS_POSTDIV])),
    .ratio(a_ratio),
    .clk_out(a_clk)
  );

  // Second synth is always software-owned, also when feeding the receiver
  synth_divider u_second (
    .clk(CLK),
    .rst(RST),
    .power_off(power_down_ff[`POS_SECOND_OFF]),
    .run(1'b1),
    .integer_part(b_frac_high_int_ff[`POS_INT_MSB:`POS_INT_LSB]),
    .fraction(join_fraction(b_frac_low_ff, b_frac_mid_ff, b_frac_high_int_ff)),
    .predivide(b_dividers_ff[`POS_PREDIV]),
    .divide_half(half_divide(b_dividers_ff[`POS_OUTDIV_MSB:`POS_OUTDIV_LSB],
                             b_dividers_ff[`POS_POSTDIV])),
    .ratio(b_ratio),
    .clk_out(b_clk)
  );

  // ****************************************
  // Registered outputs
  // ****************************************
  // Every top output comes from a flip-flop, one cycle behind its source
  always @(posedge CLK) begin
    if (RST) begin
      CRYSTAL_DRIVE_ON <= 1'b1;
      TRACKING_MODE <= 1'b0;
      FIRST_SYNTH_RATIO <= 26'h0000000;
      SECOND_SYNTH_RATIO <= 26'h0000000;
      FIRST_SYNTH_PREDIVIDE <= 1'b0;
      SECOND_SYNTH_PREDIVIDE <= 1'b0;
      FIRST_SYNTH_OUTDIV_MODE <= 2'h0;
      FIRST_SYNTH_OUT <= 1'b0;
      SECOND_SYNTH_OUT <= 1'b0;
      FIRST_SYNTH_AVAILABLE <= 1'b0;
      SECOND_SYNTH_AVAILABLE <= 1'b0;
      TRACK_FS_RATIO <= 9'h000;
      MASTER_CLOCK_FROM_OSC <= 1'b0;
      CLOCK_OUTPUT_FROM_OSC <= 1'b0;
    end else begin
      CRYSTAL_DRIVE_ON <= ~power_down_ff[`POS_CRYSTAL_OFF];
      TRACKING_MODE <= tracking;
      FIRST_SYNTH_RATIO <= a_ratio;
      SECOND_SYNTH_RATIO <= b_ratio;
      FIRST_SYNTH_PREDIVIDE <= a_dividers_ff[`POS_PREDIV];
      SECOND_SYNTH_PREDIVIDE <= b_dividers_ff[`POS_PREDIV];
      FIRST_SYNTH_OUTDIV_MODE <= a_mode;
      FIRST_SYNTH_OUT <= a_clk;
      SECOND_SYNTH_OUT <= b_clk;
      // Not offered to consumers while off, stopped, or reserved for the receiver
      FIRST_SYNTH_AVAILABLE <= ~power_down_ff[`POS_FIRST_OFF] & a_run;
      SECOND_SYNTH_AVAILABLE <= ~power_down_ff[`POS_SECOND_OFF] & ~tracking;
      // Tracking clock multiple: 256fs, halved to 128fs by the postdivide bit
      TRACK_FS_RATIO <= ~tracking ? 9'h000 :
                        (a_dividers_ff[`POS_POSTDIV] ? (`TRACK_RATIO >> 1) :
                         `TRACK_RATIO);
      MASTER_CLOCK_FROM_OSC <= OSC_SELECT_MASTER;
      CLOCK_OUTPUT_FROM_OSC <= OSC_SELECT_CLOCK_OUTPUT_PIN;
    end
  end

  // ****************************************
  // Register readback
  // ****************************************
  // Read data lands one cycle after RD_EN; unmapped addresses read zero
  always @(posedge CLK) begin
    if (RST) begin
      RDATA <= 9'h000;
      RD_VALID <= 1'b0;
    end else begin
      RD_VALID <= RD_EN;
      if (RD_EN) begin
        case (ADDR)
          `OFS_A_FRAC_LOW: RDATA <= a_frac_low_ff;
          `OFS_A_FRAC_MID: RDATA <= a_frac_mid_ff;
          `OFS_A_FRAC_HIGH_INT: RDATA <= a_frac_high_int_ff;
          `OFS_A_DIVIDERS: RDATA <= a_dividers_ff;
          `OFS_B_FRAC_LOW: RDATA <= b_frac_low_ff;
          `OFS_B_FRAC_MID: RDATA <= b_frac_mid_ff;
          `OFS_B_FRAC_HIGH_INT: RDATA <= b_frac_high_int_ff;
          `OFS_B_DIVIDERS: RDATA <= b_dividers_ff;
          `OFS_POWER_DOWN: RDATA <= power_down_ff;
          default: RDATA <= 9'h000;
        endcase
      end
    end
  end
endmodule

// ### rtl/clkmgr_consts.vh
// Register offsets, field positions, reset values and timing counts of the clock manager
`ifndef CLKMGR_CONSTS_VH
`define CLKMGR_CONSTS_VH
// ****************************************
// Register offsets (7-bit control address)
// ****************************************
`define OFS_A_FRAC_LOW 7'h00
`define OFS_A_FRAC_MID 7'h01
`define OFS_A_FRAC_HIGH_INT 7'h02
`define OFS_A_DIVIDERS 7'h03
`define OFS_B_FRAC_LOW 7'h04
`define OFS_B_FRAC_MID 7'h05
`define OFS_B_FRAC_HIGH_INT 7'h06
`define OFS_B_DIVIDERS 7'h07
`define OFS_POWER_DOWN 7'h33
// ****************************************
// Field positions
// ****************************************
`define POS_FRAC_HIGH_LSB 0
`define POS_FRAC_HIGH_MSB 3
`define POS_INT_LSB 4
`define POS_INT_MSB 7
`define POS_PREDIV 0
`define POS_POSTDIV 1
`define POS_OUTDIV_LSB 3
`define POS_OUTDIV_MSB 4
`define POS_CRYSTAL_OFF 0
`define POS_FIRST_OFF 1
`define POS_SECOND_OFF 2
// ****************************************
// Reset values
// ****************************************
`define RST_FRAC_LOW 9'h121
`define RST_FRAC_MID 9'h17e
`define RST_FRAC_HIGH_INT 9'h07d
`define RST_DIVIDERS 9'h010
`define RST_POWER_DOWN 9'h006
// ****************************************
// Fixed ratios and timing counts
// ****************************************
`define TRACK_RATIO 9'h100
`define FRAC_BITS 22
`define SYNC_STAGES 3
`endif

// ### rtl/synth_divider.v
// One synthesiser channel model: ratio, output division and clock gating
`include "clkmgr_consts.vh"
module synth_divider (
  input wire clk,
  input wire rst,
  input wire power_off,
  input wire run,
  input wire [3:0] integer_part,
  input wire [21:0] fraction,
  input wire predivide,
  input wire [4:0] divide_half,
  output wire [25:0] ratio,
  output wire clk_out
);
  // ****************************************
  // Ratio and divided clock
  // ****************************************
  reg [4:0] count_ff;
  reg out_ff;
  wire [4:0] nxt_count;
  wire nxt_out;
  wire toggle;

  // Multiplication factor: integer plus fraction over 2^22
  assign ratio = {integer_part, fraction};

  assign toggle = (count_ff + 5'h01 >= divide_half);
  assign nxt_count = toggle ? 5'h00 : count_ff + 5'h01;
  // Off or stopped forces the output low at the next edge, cutting any high phase short
  assign nxt_out = (power_off | ~run) ? 1'b0 : (toggle ? ~out_ff : out_ff);

  // Count runs only while enabled so restart is phase-clean
  always @(posedge clk) begin
    if (rst | power_off | ~run) begin
      count_ff <= 5'h00;
    end else begin
      count_ff <= nxt_count;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      out_ff <= 1'b0;
    end else begin
      out_ff <= nxt_out;
    end
  end

  assign clk_out = out_ff;
endmodule

// ### verification/osc_source.sv
// Oscillator clock source standing outside the clock manager
// ****************************************
// Free-running reference
// ****************************************
module osc_source (
  output logic clk
);
  timeunit 1ns;
  timeprecision 1ns;
  // Never stops: both synths depend on it while enabled
  initial clk = 1'b0;
  always #25 clk = ~clk;
endmodule

// ### verification/clkmgr_monitor.sv
// Port checker for the clock manager
// ****************************************
// Checker
// ****************************************
module clkmgr_monitor (
  input wire CLK,
  input wire RST,
  input wire WR_EN,
  input wire RD_EN,
  input wire [6:0] ADDR,
  input wire [8:0] WDATA,
  input wire [8:0] RDATA,
  input wire RD_VALID,
  input wire RX_ENABLE,
  input wire RX_LOCKED,
  input wire RX_STREAM_PRESENT,
  input wire [3:0] RX_INTEGER,
  input wire [21:0] RX_FRACTION,
  input wire [1:0] RX_OUTDIV_MODE,
  input wire OSC_SELECT_MASTER,
  input wire OSC_SELECT_CLOCK_OUTPUT_PIN,
  input wire CRYSTAL_DRIVE_ON,
  input wire TRACKING_MODE,
  input wire [25:0] FIRST_SYNTH_RATIO,
  input wire [25:0] SECOND_SYNTH_RATIO,
  input wire [1:0] FIRST_SYNTH_OUTDIV_MODE,
  input wire FIRST_SYNTH_OUT,
  input wire SECOND_SYNTH_OUT,
  input wire FIRST_SYNTH_AVAILABLE,
  input wire [8:0] TRACK_FS_RATIO,
  input wire MASTER_CLOCK_FROM_OSC,
  input wire CLOCK_OUTPUT_FROM_OSC
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  logic [8:0] r_ff [0:7];
  logic [8:0] pd_ff;
  // Shadow of the writable registers; unused 33h bits kept at zero
  always @(posedge CLK) begin
    if (RST) begin
      pd_ff <= 9'h006;
      for (int i = 0; i < 8; i++)
        r_ff[i] <= (i % 4 == 0) ? 9'h121 : (i % 4 == 1) ? 9'h17e : (i % 4 == 2) ? 9'h07d : 9'h010;
    end else if (WR_EN) begin
      if (ADDR == 7'h33)
        pd_ff <= WDATA & 9'h007;
      if (ADDR < 7'h08)
        r_ff[ADDR[2:0]] <= WDATA;
    end
  end
  // Settle windows: derived outputs lag a write by up to two cycles
  sequence s_q;
    !WR_EN [*3];
  endsequence
  sequence s_rx;
    TRACKING_MODE && RX_STREAM_PRESENT && $stable(RX_FRACTION) && $stable(RX_INTEGER);
  endsequence
  a_read_back: assert property (RD_EN && ADDR == 7'h33 |=> RD_VALID && RDATA == $past(pd_ff))
    else $error("power-down readback wrong");
  a_crystal_drive: assert property (s_q |-> CRYSTAL_DRIVE_ON == !pd_ff[0])
    else $error("crystal drive not per bit 0");
  a_synth_gated: assert property (s_q |->
    (!pd_ff[1] || (!FIRST_SYNTH_OUT && !FIRST_SYNTH_AVAILABLE))
    && (!pd_ff[2] || !SECOND_SYNTH_OUT))
    else $error("powered-down synth not static");
  a_mode_follow: assert property ($stable(RX_ENABLE) [*8] |-> TRACKING_MODE == RX_ENABLE)
    else $error("mode does not follow receiver enable");
  a_user_apply: assert property ((!TRACKING_MODE && !WR_EN) [*3] |->
    FIRST_SYNTH_RATIO == {r_ff[2][7:0], r_ff[1], r_ff[0]}
    && SECOND_SYNTH_RATIO == {r_ff[6][7:0], r_ff[5], r_ff[4]}
    && FIRST_SYNTH_OUTDIV_MODE == r_ff[3][4:3])
    else $error("user values not applied");
  a_rx_owns: assert property (s_rx [*8] |->
    FIRST_SYNTH_RATIO == {RX_INTEGER, RX_FRACTION}
    && FIRST_SYNTH_OUTDIV_MODE == RX_OUTDIV_MODE)
    else $error("receiver does not own first synth");
  a_fs_ratio: assert property ((!WR_EN && $stable(TRACKING_MODE)) [*3] |->
    TRACK_FS_RATIO == (TRACKING_MODE ? (r_ff[3][1] ? 9'h080 : 9'h100) : 9'h000))
    else $error("tracking ratio wrong");
  a_unlock_stop: assert property ((TRACKING_MODE && RX_STREAM_PRESENT && !RX_LOCKED) [*8]
    |-> !FIRST_SYNTH_OUT)
    else $error("first synth runs while unlocked");
  a_ratio_freeze: assert property ((TRACKING_MODE && !RX_STREAM_PRESENT) [*8]
    |-> $stable(FIRST_SYNTH_RATIO))
    else $error("ratio not frozen on stream loss");
  a_osc_mirror: assert property (MASTER_CLOCK_FROM_OSC == $past(OSC_SELECT_MASTER)
    && CLOCK_OUTPUT_FROM_OSC == $past(OSC_SELECT_CLOCK_OUTPUT_PIN))
    else $error("oscillator selection not mirrored");
endmodule
bind clock_manager clkmgr_monitor clkmgr_monitor_i (.*);

// ### verification/clock_manager_bench.sv
// Self-checking bench for the clock manager
`define CHK(nm, e, a) begin num_checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("mismatch %s exp %0h got %0h", nm, e, a); end end
// ****************************************
// Bench
// ****************************************
module clock_manager_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK, RST, WR_EN, RD_EN, RX_ENABLE, RX_LOCKED, RX_STREAM_PRESENT, RD_VALID;
  logic OSC_SELECT_MASTER, OSC_SELECT_CLOCK_OUTPUT_PIN, CRYSTAL_DRIVE_ON, TRACKING_MODE;
  logic FIRST_SYNTH_PREDIVIDE, SECOND_SYNTH_PREDIVIDE, FIRST_SYNTH_OUT, SECOND_SYNTH_OUT;
  logic FIRST_SYNTH_AVAILABLE, SECOND_SYNTH_AVAILABLE, MASTER_CLOCK_FROM_OSC, CLOCK_OUTPUT_FROM_OSC;
  logic [6:0] ADDR;
  logic [8:0] WDATA, RDATA, TRACK_FS_RATIO;
  logic [3:0] RX_INTEGER;
  logic [21:0] RX_FRACTION;
  logic [1:0] RX_OUTDIV_MODE, FIRST_SYNTH_OUTDIV_MODE;
  logic [25:0] FIRST_SYNTH_RATIO, SECOND_SYNTH_RATIO;
  logic [8:0] rv [0:3] = '{9'h121, 9'h17e, 9'h07d, 9'h010};
  logic s;
  int n_mismatch = 0;
  int num_checks = 0;
  osc_source osc_source_i (.clk(CLK));
  clock_manager clock_manager_i (.*);
  task end_sim;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  task wr(input logic [6:0] a, input logic [8:0] d);
    @(posedge CLK);
    WR_EN <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge CLK);
    WR_EN <= 1'b0;
  endtask
  // Answer lands exactly one cycle after the strobe
  task rd(input logic [6:0] a, input logic [8:0] e);
    @(posedge CLK);
    RD_EN <= 1'b1;
    ADDR <= a;
    @(posedge CLK);
    RD_EN <= 1'b0;
    #1;
    `CHK("rd_valid", 1'b1, RD_VALID)
    `CHK("rdata", e, RDATA)
  endtask
  // Any high sample in 40 cycles; slowest divider halves in 12
  task seen;
    s = 1'b0;
    repeat (40) begin
      @(posedge CLK);
      #1;
      s |= FIRST_SYNTH_OUT;
    end
  endtask
  task t_reset_values;
    for (int i = 0; i < 8; i++)
      rd(i[6:0], rv[i % 4]);
    rd(7'h33, 9'h006);
    rd(7'h10, 9'h000);
  endtask
  task t_power;
    wr(7'h33, 9'h1ff);
    rd(7'h33, 9'h007);
    cyc(4);
    `CHK("xtal_off", 1'b0, CRYSTAL_DRIVE_ON)
    `CHK("a_avail", 1'b0, FIRST_SYNTH_AVAILABLE)
    `CHK("b_out", 1'b0, SECOND_SYNTH_OUT)
    wr(7'h33, 9'h000);
    cyc(4);
    `CHK("xtal_on", 1'b1, CRYSTAL_DRIVE_ON)
    `CHK("b_avail", 1'b1, SECOND_SYNTH_AVAILABLE)
  endtask
  task t_user;
    wr(7'h00, 9'h0ba);
    wr(7'h01, 9'h124);
    wr(7'h02, 9'h08c);
    wr(7'h03, 9'h01b);
    wr(7'h06, 9'h0d5);
    cyc(3);
    `CHK("a_ratio", {4'h8, 4'hc, 9'h124, 9'h0ba}, FIRST_SYNTH_RATIO)
    `CHK("b_ratio", {4'hd, 4'h5, 9'h17e, 9'h121}, SECOND_SYNTH_RATIO)
    `CHK("a_outdiv", 2'b11, FIRST_SYNTH_OUTDIV_MODE)
    `CHK("a_prediv", 1'b1, FIRST_SYNTH_PREDIVIDE)
    `CHK("b_prediv", 1'b0, SECOND_SYNTH_PREDIVIDE)
    seen();
    `CHK("a_runs", 1'b1, s)
  endtask
  task t_track;
    wr(7'h03, 9'h018);
    wr(7'h06, 9'h07d);
    @(posedge CLK);
    RX_INTEGER <= 4'h9;
    RX_FRACTION <= 22'h2aaaa5;
    RX_OUTDIV_MODE <= 2'b01;
    RX_LOCKED <= 1'b1;
    RX_STREAM_PRESENT <= 1'b1;
    RX_ENABLE <= 1'b1;
    wr(7'h00, 9'h000);
    cyc(10);
    `CHK("track", 1'b1, TRACKING_MODE)
    `CHK("rx_ratio", {4'h9, 22'h2aaaa5}, FIRST_SYNTH_RATIO)
    `CHK("rx_outdiv", 2'b01, FIRST_SYNTH_OUTDIV_MODE)
    `CHK("fs256", 9'h100, TRACK_FS_RATIO)
    `CHK("b_gone", 1'b0, SECOND_SYNTH_AVAILABLE)
    `CHK("prediv_eq", 1'b0, FIRST_SYNTH_PREDIVIDE)
    wr(7'h03, 9'h01a);
    cyc(3);
    `CHK("fs128", 9'h080, TRACK_FS_RATIO)
    @(posedge CLK);
    RX_STREAM_PRESENT <= 1'b0;
    cyc(10);
    @(posedge CLK);
    RX_FRACTION <= 22'h011111;
    cyc(10);
    `CHK("frozen", {4'h9, 22'h2aaaa5}, FIRST_SYNTH_RATIO)
    seen();
    `CHK("free_run", 1'b1, s)
    @(posedge CLK);
    RX_STREAM_PRESENT <= 1'b1;
    RX_LOCKED <= 1'b0;
    cyc(10);
    seen();
    `CHK("stopped", 1'b0, s)
    @(posedge CLK);
    RX_LOCKED <= 1'b1;
    cyc(10);
    seen();
    `CHK("relock", 1'b1, s)
    `CHK("retrack", {4'h9, 22'h011111}, FIRST_SYNTH_RATIO)
    @(posedge CLK);
    RX_ENABLE <= 1'b0;
    cyc(10);
    `CHK("user", {4'h8, 4'hc, 9'h124, 9'h000}, FIRST_SYNTH_RATIO)
    `CHK("fs_off", 9'h000, TRACK_FS_RATIO)
  endtask
  task t_osc;
    @(posedge CLK);
    OSC_SELECT_MASTER <= 1'b1;
    cyc(2);
    `CHK("mclk_osc", 1'b1, MASTER_CLOCK_FROM_OSC)
    `CHK("clock_output_pin_osc", 1'b0, CLOCK_OUTPUT_FROM_OSC)
    @(posedge CLK);
    OSC_SELECT_MASTER <= 1'b0;
    OSC_SELECT_CLOCK_OUTPUT_PIN <= 1'b1;
    cyc(2);
    `CHK("clock_output_pin_osc2", 1'b1, CLOCK_OUTPUT_FROM_OSC)
  endtask
  // Main sequence: reset held five cycles, then each scenario
  initial begin
    {RST, WR_EN, RD_EN, ADDR, WDATA} = {1'b1, 18'h0};
    {RX_ENABLE, RX_LOCKED, RX_STREAM_PRESENT, RX_INTEGER, RX_FRACTION, RX_OUTDIV_MODE} = '0;
    {OSC_SELECT_MASTER, OSC_SELECT_CLOCK_OUTPUT_PIN} = 2'b00;
    repeat (5) @(posedge CLK);
    RST <= 1'b0;
    t_reset_values();
    t_power();
    t_user();
    t_track();
    t_osc();
    end_sim();
  end
  // Hang guard, well beyond the few hundred cycles the scenarios need
  initial begin
    repeat (5000) @(posedge CLK);
    n_mismatch++;
    end_sim();
  end
endmodule
